//--- hw/ted_defs.vh
`ifndef TED_DEFS_VH
`define TED_DEFS_VH

// Lane and word geometry.
`define TED_LANES       4
`define TED_BYTE_W      8
`define TED_CODE_W      10
`define TED_FIFO_DEPTH  8

// Field positions inside a queued fabric word.
`define TED_F_DATA      0
`define TED_F_KFLAG     32
`define TED_F_DMODE     36
`define TED_F_DVAL      40
`define TED_F_BYPASS    44
`define TED_F_WIDTH     48

// Fabric width select encodings.
`define TED_FW_1BYTE    2'h0
`define TED_FW_2BYTE    2'h1

// Disparity force encodings, {mode, value}.
`define TED_DF_NORMAL   2'h0
`define TED_DF_INVERT   2'h1
`define TED_DF_NEG      2'h2
`define TED_DF_POS      2'h3

// Code constants and reset values.
`define TED_K28         5'h1c
`define TED_K28_CODE6   6'h0f
`define TED_ALT7_CODE4  4'h7
`define TED_RD_RESET    1'h0

`endif

//--- hw/ted_encoder.v
`include "ted_defs.vh"
`default_nettype none

module ted_encoder #(
   parameter NUM_CH     = 2,
   parameter FIFO_DEPTH = `TED_FIFO_DEPTH
)(
   // Clock and reset
   input  wire                  clk,
   input  wire                  rst_n,
   // Per-channel configuration
   input  wire [NUM_CH-1:0]     encoder_use,
   input  wire [NUM_CH-1:0]     internal_width_select,
   input  wire [2*NUM_CH-1:0]   fabric_width_select,
   // Fabric transmit words and per-lane flags
   input  wire [NUM_CH-1:0]     in_valid,
   output wire [NUM_CH-1:0]     in_ready,
   input  wire [32*NUM_CH-1:0]  tx_word,
   input  wire [4*NUM_CH-1:0]   control_char_flag,
   input  wire [4*NUM_CH-1:0]   lane_encode_bypass,
   input  wire [4*NUM_CH-1:0]   disparity_force_mode,
   input  wire [4*NUM_CH-1:0]   disparity_force_value,
   // Code words toward the serializer
   output wire [NUM_CH-1:0]     out_valid,
   input  wire [NUM_CH-1:0]     out_ready,
   output wire [40*NUM_CH-1:0]  tx_code,
   output wire [4*NUM_CH-1:0]   control_char_error,
   output wire [4*NUM_CH-1:0]   running_disparity_out
);

   localparam LN = `TED_LANES;
   localparam BW = `TED_BYTE_W;
   localparam CW = `TED_CODE_W;
   localparam QW = `TED_F_WIDTH + 2;

   // Six-bit data codes for negative disparity, written abcdei; the caller flips them.
   function [5:0] ted_code6;
      input [4:0] x;
      begin
         case (x)
            5'h00:   ted_code6 = 6'h27;
            5'h01:   ted_code6 = 6'h1d;
            5'h02:   ted_code6 = 6'h2d;
            5'h03:   ted_code6 = 6'h31;
            5'h04:   ted_code6 = 6'h35;
            5'h05:   ted_code6 = 6'h29;
            5'h06:   ted_code6 = 6'h19;
            5'h07:   ted_code6 = 6'h38;
            5'h08:   ted_code6 = 6'h39;
            5'h09:   ted_code6 = 6'h25;
            5'h0a:   ted_code6 = 6'h15;
            5'h0b:   ted_code6 = 6'h34;
            5'h0c:   ted_code6 = 6'h0d;
            5'h0d:   ted_code6 = 6'h2c;
            5'h0e:   ted_code6 = 6'h1c;
            5'h0f:   ted_code6 = 6'h17;
            5'h10:   ted_code6 = 6'h1b;
            5'h11:   ted_code6 = 6'h23;
            5'h12:   ted_code6 = 6'h13;
            5'h13:   ted_code6 = 6'h32;
            5'h14:   ted_code6 = 6'h0b;
            5'h15:   ted_code6 = 6'h2a;
            5'h16:   ted_code6 = 6'h1a;
            5'h17:   ted_code6 = 6'h3a;
            5'h18:   ted_code6 = 6'h33;
            5'h19:   ted_code6 = 6'h26;
            5'h1a:   ted_code6 = 6'h16;
            5'h1b:   ted_code6 = 6'h36;
            5'h1c:   ted_code6 = 6'h0e;
            5'h1d:   ted_code6 = 6'h2e;
            5'h1e:   ted_code6 = 6'h1e;
            5'h1f:   ted_code6 = 6'h2b;
            default: ted_code6 = 6'h00;
         endcase
      end
   endfunction

   // Four-bit codes for negative disparity, written fghj; the caller flips them.
   function [3:0] ted_code4;
      input [2:0] y;
      begin
         case (y)
            3'h0:    ted_code4 = 4'hb;
            3'h1:    ted_code4 = 4'h9;
            3'h2:    ted_code4 = 4'h5;
            3'h3:    ted_code4 = 4'hc;
            3'h4:    ted_code4 = 4'hd;
            3'h5:    ted_code4 = 4'ha;
            3'h6:    ted_code4 = 4'h6;
            3'h7:    ted_code4 = 4'he;
            default: ted_code4 = 4'h0;
         endcase
      end
   endfunction

   // Encodes one byte from the given disparity; returns {new rd, code}.
   function [10:0] ted_enc8;
      input [7:0] b;
      input       k;
      input       rd;
      reg   [5:0] c6;
      reg   [3:0] c4;
      reg   [9:0] w;
      reg   [4:0] x;
      reg   [2:0] y;
      reg         rdm;
      reg         u6;
      reg         u4;
      reg         a7;
      integer     i;
      integer     n6;
      integer     n4;
      begin
         x  = b[4:0];
         y  = b[7:5];
         c6 = (k && x == `TED_K28) ? `TED_K28_CODE6 : ted_code6(x);
         n6 = 0;
         for (i = 0; i < 6; i = i + 1)
            n6 = n6 + c6[i];
         u6 = (n6 != 3);
         // Balanced D.7 still alternates, so it flips too.
         if (rd && (u6 || x == 5'h07))
            c6 = ~c6;
         rdm = rd ^ u6;
         a7 = (y == 3'h7) && (k || (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14))
              || (rdm && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
         c4 = a7 ? `TED_ALT7_CODE4 : ted_code4(y);
         n4 = 0;
         for (i = 0; i < 4; i = i + 1)
            n4 = n4 + c4[i];
         u4 = (n4 != 2);
         if (rdm && (u4 || y == 3'h3))
            c4 = ~c4;
         else if (k && x == `TED_K28 && !u4 && y != 3'h3 && !rdm)
            c4 = ~c4;
         w = {c6, c4};
         for (i = 0; i < 10; i = i + 1)
            ted_enc8[i] = w[9-i];
         ted_enc8[10] = rdm ^ u4;
      end
   endfunction

   // True for the twelve control characters of the code.
   function ted_kvalid;
      input [7:0] b;
      begin
         ted_kvalid = (b[4:0] == `TED_K28) || (b[7:5] == 3'h7 &&
            (b[4:0] == 5'h17 || b[4:0] == 5'h1b || b[4:0] == 5'h1d || b[4:0] == 5'h1e));
      end
   endfunction

   // Puts lane-ordered status bits into the port order for a fabric width.
   function [3:0] ted_map;
      input [3:0] v;
      input [1:0] fw;
      begin
         if (fw == `TED_FW_1BYTE)
            ted_map = {3'h0, v[0]};
         else if (fw == `TED_FW_2BYTE)
            ted_map = {2'h0, v[0], v[1]};
         else
            ted_map = {v[1], v[0], v[3], v[2]};
      end
   endfunction

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c = c + 1)
      begin : g_ch
         wire [QW-1:0]    q_in;
         wire [QW-1:0]    f_data;
         wire             f_valid;
         reg              f_ready;
         reg              s1_valid_reg;
         reg  [QW-1:0]    s1_data_reg;
         reg              s2_valid_reg;
         reg  [LN*CW-1:0] code_reg;
         reg  [3:0]       err_reg;
         reg  [3:0]       lane_rd_reg;
         reg  [3:0]       rund_reg;
         reg              rd_reg;
         reg              s2_free;
         reg              s1_load;
         reg              s2_load;
         reg  [QW-1:0]    src;
         reg              enc_on;
         reg              byp_ok;
         reg              r;
         reg              rin;
         reg  [10:0]      e;
         reg  [2:0]       nl;
         reg  [LN*CW-1:0] code_next;
         reg  [3:0]       err_next;
         reg  [3:0]       lane_rd_next;
         integer          l;

         assign q_in = {fabric_width_select[2*c +: 2],
                        lane_encode_bypass[4*c +: 4],
                        disparity_force_value[4*c +: 4],
                        disparity_force_mode[4*c +: 4],
                        control_char_flag[4*c +: 4],
                        tx_word[32*c +: 32]};

         ted_fifo #(
            .WIDTH (QW),
            .DEPTH (FIFO_DEPTH)
         ) u_fifo (
            .clk       (clk),
            .rst_n     (rst_n),
            .in_valid  (in_valid[c]),
            .in_ready  (in_ready[c]),
            .in_data   (q_in),
            .out_valid (f_valid),
            .out_ready (f_ready),
            .out_data  (f_data)
         );

         // Encoded words take two stages and raw words one, so a word already in
         // the first stage is always drained first to keep the order.
         always @*
         begin
            s2_free = !s2_valid_reg || out_ready[c];
            if (encoder_use[c])
               f_ready = !s1_valid_reg || s2_free;
            else
               f_ready = s2_free && !s1_valid_reg;
            s1_load = encoder_use[c] && f_valid && f_ready;
            s2_load = s2_free && (s1_valid_reg || (!encoder_use[c] && f_valid));
         end

         always @*
         begin
            src          = s1_valid_reg ? s1_data_reg : f_data;
            enc_on       = s1_valid_reg;
            byp_ok       = encoder_use[c] && internal_width_select[c];
            nl           = (src[QW-1 -: 2] == `TED_FW_1BYTE) ? 3'h1 :
                           (src[QW-1 -: 2] == `TED_FW_2BYTE) ? 3'h2 : 3'h4;
            r            = rd_reg;
            rin          = 1'b0;
            e            = 11'h000;
            code_next    = {(LN*CW){1'b0}};
            err_next     = 4'h0;
            lane_rd_next = lane_rd_reg;
            for (l = 0; l < LN; l = l + 1)
            begin
               if (l < nl && enc_on && !(byp_ok && src[`TED_F_BYPASS + l]))
               begin
                  case ({src[`TED_F_DMODE + l], src[`TED_F_DVAL + l]})
                     `TED_DF_NORMAL: rin = r;
                     `TED_DF_INVERT: rin = ~r;
                     `TED_DF_NEG:    rin = 1'b0;
                     `TED_DF_POS:    rin = 1'b1;
                     default:        rin = r;
                  endcase
                  e = ted_enc8(src[BW*l +: BW], src[`TED_F_KFLAG + l], rin);
                  code_next[CW*l +: CW] = e[9:0];
                  r = e[10];
                  lane_rd_next[l] = e[10];
                  err_next[l] = src[`TED_F_KFLAG + l] && !ted_kvalid(src[BW*l +: BW]);
               end
               else if (l < nl)
               begin
                  code_next[CW*l +: CW] = {src[`TED_F_DVAL + l], src[`TED_F_DMODE + l],
                                           src[BW*l +: BW]};
               end
            end
         end

         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               s1_valid_reg <= 1'b0;
               s1_data_reg  <= {QW{1'b0}};
               s2_valid_reg <= 1'b0;
               code_reg     <= {(LN*CW){1'b0}};
               err_reg      <= 4'h0;
               lane_rd_reg  <= 4'h0;
               rund_reg     <= 4'h0;
               rd_reg       <= `TED_RD_RESET;
            end
            else
            begin
               if (s1_load)
                  s1_data_reg <= f_data;
               s1_valid_reg <= s1_load || (s1_valid_reg && !s2_load);
               s2_valid_reg <= s2_load || (s2_valid_reg && !out_ready[c]);
               if (s2_load)
               begin
                  code_reg <= code_next;
                  err_reg  <= ted_map(err_next, src[QW-1 -: 2]);
                  if (enc_on)
                  begin
                     rd_reg      <= r;
                     lane_rd_reg <= lane_rd_next;
                     rund_reg    <= ted_map(lane_rd_next, src[QW-1 -: 2]);
                  end
               end
            end
         end

         assign out_valid[c]                   = s2_valid_reg;
         assign tx_code[40*c +: 40]            = code_reg;
         assign control_char_error[4*c +: 4]   = err_reg;
         assign running_disparity_out[4*c +: 4] = rund_reg;
      end
   endgenerate

endmodule // ted_encoder

`default_nettype wire

//--- hw/ted_fifo.v
`default_nettype none

module ted_fifo #(
   parameter WIDTH = 48,
   parameter DEPTH = 8
)(
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Filling side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Draining side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr_reg;
   reg  [AW-1:0]    rd_ptr_reg;
   reg  [AW:0]      count_reg;
   wire             push;
   wire             pop;

   assign in_ready  = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage has no reset; only the pointers and the count carry state.
   always @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_reg] <= in_data;
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end

endmodule // ted_fifo

`default_nettype wire

//--- verif/ted_encoder_props.sv
`default_nettype none
module ted_encoder_props #(
   parameter NUM_CH     = 2,
   parameter FIFO_DEPTH = 8
)(
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 rst_n,
   // Watched ports
   input wire logic [NUM_CH-1:0]    encoder_use,
   input wire logic [NUM_CH-1:0]    in_valid,
   input wire logic [NUM_CH-1:0]    in_ready,
   input wire logic [NUM_CH-1:0]    out_valid,
   input wire logic [NUM_CH-1:0]    out_ready,
   input wire logic [40*NUM_CH-1:0] tx_code,
   input wire logic [4*NUM_CH-1:0]  control_char_error,
   input wire logic [4*NUM_CH-1:0]  running_disparity_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Words held in channel 0, queue and both stages together.
   logic [4:0] occ_reg;
   logic       take;
   logic       give;
   assign take = in_valid[0] && in_ready[0];
   assign give = out_valid[0] && out_ready[0];
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         occ_reg <= 5'h0;
      else
         occ_reg <= occ_reg + {4'h0, take} - {4'h0, give};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_code_hold: assert property (out_valid[0] && !out_ready[0] |=>
      out_valid[0] && $stable(tx_code[39:0])) else $error("word changed under stall");
   a_rund_quiet: assert property ($changed(running_disparity_out[3:0]) |-> out_valid[0])
      else $error("disparity moved without a word");
   a_enc_latency: assert property (take && occ_reg == 5'h0 ##1 encoder_use[0] |=>
      !out_valid[0] ##1 out_valid[0]) else $error("encoded latency wrong");
   a_raw_latency: assert property (take && occ_reg == 5'h0 ##1 !encoder_use[0] |->
      !out_valid[0] ##1 out_valid[0]) else $error("raw latency wrong");
   a_no_phantom: assert property ($rose(out_valid[0]) |-> occ_reg != 5'h0)
      else $error("word out with nothing taken");
   a_room_ready: assert property (occ_reg < FIFO_DEPTH |-> in_ready[0])
      else $error("refused with room left");
   a_depth_cap: assert property (occ_reg <= FIFO_DEPTH + 2)
      else $error("too many words held");
   a_reset_idle: assert property ($rose(rst_n) |-> in_ready[0] && !out_valid[0] &&
      running_disparity_out == '0 && control_char_error == '0) else $error("not idle");
   c_raw: cover property (take && occ_reg == 5'h0 ##1 !encoder_use[0]);
   c_full: cover property (!in_ready[0]);
   c_kerr: cover property (out_valid[0] && control_char_error[3:0] != 4'h0);
endmodule // ted_encoder_props
bind ted_encoder ted_encoder_props #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH))
   ted_encoder_props_inst (.clk, .rst_n, .encoder_use, .in_valid, .in_ready, .out_valid,
   .out_ready, .tx_code, .control_char_error, .running_disparity_out);
`default_nettype wire

//--- verif/ted_sink.sv
`default_nettype none
module ted_sink (
   // Pacing from the bench
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        stall,
   input  wire logic        slow,
   // Code word side
   input  wire logic        valid,
   output logic             ready,
   input  wire logic [39:0] code,
   input  wire logic [3:0]  err,
   input  wire logic [3:0]  rund,
   // Last word taken
   output logic [39:0]      got_code,
   output logic [3:0]       got_err,
   output logic [3:0]       got_rund,
   output logic [7:0]       n_got
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pace_reg;
   // A slow sink takes only every other cycle, so stages must hold.
   assign ready = !stall && (!slow || pace_reg);
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         pace_reg <= 1'b0;
         n_got    <= 8'h0;
      end
      else
      begin
         pace_reg <= !pace_reg;
         if (valid && ready)
         begin
            got_code <= code;
            got_err  <= err;
            got_rund <= rund;
            n_got    <= n_got + 8'h1;
         end
      end
endmodule // ted_sink
`default_nettype wire

//--- verif/test_ted_encoder.sv
`default_nettype none
module test_ted_encoder;
   timeunit 1ns;
   timeprecision 1ps;
   // Rows: {use, flag, mode, value}, byte, lane 0 code, disparity after.
   localparam logic [22:0] ROWS [7] = '{
      {4'b1100, 8'hbc, 10'h17c, 1'b1}, {4'b1100, 8'hbc, 10'h283, 1'b0},
      {4'b1101, 8'hbc, 10'h283, 1'b0}, {4'b1111, 8'hbc, 10'h283, 1'b0},
      {4'b1110, 8'hbc, 10'h17c, 1'b1}, {4'b1000, 8'hb5, 10'h155, 1'b1},
      {4'b0010, 8'h5a, 10'h15a, 1'b1}};
   localparam logic [39:0] MASK = 40'hfffff003ff;
   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   logic        stall = 1'b0;
   logic        slow  = 1'b0;
   logic [1:0]  eu    = 2'b11;
   logic [1:0]  iws   = 2'b11;
   logic [3:0]  fws   = 4'h0;
   logic [1:0]  iv    = 2'b00;
   logic [63:0] tx    = 64'h0;
   logic [7:0]  kf    = 8'h0;
   logic [7:0]  byp   = 8'h0;
   logic [7:0]  dm    = 8'h0;
   logic [7:0]  dv    = 8'h0;
   logic [1:0]  ir, ov, ordy;
   logic [79:0] code, got_code;
   logic [7:0]  cerr, rund, got_err, got_rund;
   logic [15:0] n_got;
   logic [22:0] row;
   int          errors  = 0;
   int          n_tests = 0;
   int          sent    = 0;
   int          acc;
   always #5 clk = ~clk;
   ted_encoder #(.NUM_CH(2), .FIFO_DEPTH(8)) ted_encoder_inst (
      .clk(clk), .rst_n(rst_n), .encoder_use(eu), .internal_width_select(iws),
      .fabric_width_select(fws), .in_valid(iv), .in_ready(ir), .tx_word(tx),
      .control_char_flag(kf), .lane_encode_bypass(byp), .disparity_force_mode(dm),
      .disparity_force_value(dv), .out_valid(ov), .out_ready(ordy), .tx_code(code),
      .control_char_error(cerr), .running_disparity_out(rund));
   ted_sink ted_sink_inst [1:0] (.clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow),
      .valid(ov), .ready(ordy), .code(code), .err(cerr), .rund(rund), .got_code(got_code),
      .got_err(got_err), .got_rund(got_rund), .n_got(n_got));
   task automatic summarize;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic stuck;
      errors++;
      summarize;
   endtask
   task automatic chk_code(input logic [79:0] g, input logic [79:0] e);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_bits(input logic [7:0] g, input logic [7:0] e);
      chk_code({72'h0, g}, {72'h0, e});
   endtask
   // Both channels get the same word, so each half checks the other.
   task automatic send(input logic u, input logic [1:0] w, input logic [31:0] d,
      input logic [3:0] k, input logic [3:0] b, input logic [3:0] m, input logic [3:0] v);
      int i;
      @(negedge clk);
      eu = {u, u};
      fws = {w, w};
      tx = {d, d};
      kf = {k, k};
      byp = {b, b};
      dm = {m, m};
      dv = {v, v};
      iv = 2'b11;
      for (i = 0; i < 40 && ir[0] !== 1'b1; i++)
         @(negedge clk);
      if (i == 40)
         stuck;
      @(negedge clk);
      iv = 2'b00;
      sent++;
   endtask
   task automatic wait_got(input int n);
      int i;
      for (i = 0; i < 60 && n_got !== {2{n[7:0]}}; i++)
         @(negedge clk);
      if (n_got !== {2{n[7:0]}})
         stuck;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int r = 0; r < 7; r++)
      begin
         row = ROWS[r];
         send(row[22], 2'h0, {24'h0, row[18:11]}, {3'h0, row[21]}, 4'h0, {3'h0, row[20]},
            {3'h0, row[19]});
         wait_got(sent);
         chk_code(got_code, {2{30'h0, row[10:1]}});
         chk_bits(got_rund & 8'h11, {2{3'h0, row[0]}});
         chk_bits(got_err & 8'h11, 8'h0);
      end
      send(1'b1, 2'h2, 32'hbcbcbcbc, 4'hf, 4'h0, 4'h1, 4'h0);
      wait_got(sent);
      chk_code(got_code, {2{10'h283, 10'h17c, 10'h283, 10'h17c}});
      chk_bits(got_rund, 8'h55);
      // Lane 1 carries a bad K byte that must pass raw while bypassed.
      send(1'b1, 2'h2, 32'hbcbc33bc, 4'hf, 4'h2, 4'h7, 4'h6);
      wait_got(sent);
      chk_code(got_code, {2{10'h17c, 10'h283, 10'h333, 10'h17c}});
      chk_bits(got_err, 8'h0);
      chk_bits(got_rund, 8'h66);
      iws = 2'b00;
      send(1'b1, 2'h2, 32'hbcbc33bc, 4'hf, 4'h2, 4'h7, 4'h6);
      wait_got(sent);
      chk_code(got_code & {2{MASK}}, {2{10'h17c, 10'h283, 10'h0, 10'h17c}});
      chk_bits(got_err, 8'h88);
      send(1'b1, 2'h1, 32'h000000bc, 4'h3, 4'h0, 4'h1, 4'h0);
      wait_got(sent);
      chk_code(got_code & {2{MASK}}, {2{30'h0, 10'h17c}});
      chk_bits(got_err, 8'h11);
      chk_bits(got_rund & 8'h22, 8'h22);
      iws = 2'b11;
      stall = 1'b1;
      {eu, fws} = 6'h0;
      {kf, byp, dm, dv} = 32'h0;
      iv = 2'b11;
      for (acc = 0; acc < 20 && ir[0] === 1'b1; acc++)
      begin
         tx = {2{24'h0, acc[7:0]}};
         @(negedge clk);
      end
      iv = 2'b00;
      sent += acc;
      chk_bits({7'h0, acc >= 8 && acc <= 10}, 8'h1);
      stall = 1'b0;
      slow = 1'b1;
      for (int j = 0; j < acc; j++)
      begin
         wait_got(sent - acc + j + 1);
         chk_code(got_code, {2{32'h0, j[7:0]}});
      end
      stall = 1'b1;
      send(1'b1, 2'h0, 32'hbc, 4'h1, 4'h0, 4'h0, 4'h0);
      repeat (3) @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      sent = 0;
      chk_bits({ir, ov, rund[3:0]}, 8'hc0);
      rst_n = 1'b1;
      stall = 1'b0;
      send(1'b1, 2'h0, 32'hbc, 4'h1, 4'h0, 4'h0, 4'h0);
      wait_got(sent);
      chk_code(got_code, {2{30'h0, 10'h17c}});
      summarize;
   end
endmodule // test_ted_encoder
`default_nettype wire
